//--- core/pmch_defs.svh
`ifndef PMCH_DEFS_SVH
`define PMCH_DEFS_SVH

// Command codes handled by this block.
`define PMCH_CMD_SYNC_OFF 8'h34
`define PMCH_CMD_SYNC_ON 8'h35
`define PMCH_CMD_SCAN_ORDER 8'h36
`define PMCH_CMD_LOW_COLOR_EXIT 8'h38
`define PMCH_CMD_LOW_COLOR_ENTRY 8'h39

// Parameter byte field positions.
`define PMCH_SYNC_HBLANK_BIT 0
`define PMCH_SCAN_COLOR_SWAP_BIT 3
`define PMCH_SCAN_SOURCE_DIR_BIT 1
`define PMCH_SCAN_GATE_DIR_BIT 0

// Reset values.
`define PMCH_SYNC_CTRL_RESET 8'h00
`define PMCH_SCAN_CTRL_RESET 8'h00

`endif

//--- core/pmch_pkg.sv
package pmch_pkg;

  typedef enum logic [1:0] {
    PMCH_L_IDLE,
    PMCH_L_PARAM,
    PMCH_L_WAIT
  } pmch_lstate_t;

  typedef logic [7:0] pmch_byte_t;

endpackage

//--- core/pmch_top.sv
`timescale 1ns/1ps
`include "pmch_defs.svh"
module pmch_top (
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  input wire logic swrst,
  input wire logic sleep_in,
  input wire logic vblank,
  input wire logic hblank,
  input wire logic pix_valid,
  input wire logic [23:0] pix_in,
  input wire logic lclk,
  input wire logic lnk_valid,
  input wire logic lnk_is_cmd,
  input wire logic [7:0] lnk_data,
  output logic lnk_busy_q,
  output logic frame_sync_out_q,
  output logic color_order_swap_q,
  output logic source_direction_q,
  output logic gate_direction_q,
  output logic low_color_q,
  output logic idle_render_q,
  output logic pix_out_valid_q,
  output logic [23:0] pix_out_q
);

  // Link domain: reset and enable are brought in through two flip-flops each.
  logic lrst_s1, lrst_s2, lce_s1, lce_s2;
  logic ack_s1, ack_s2, ack_q, ack_d;
  pmch_pkg::pmch_lstate_t lstate_q, lstate_d;
  pmch_pkg::pmch_byte_t cmd_hold_q, cmd_hold_d, par_hold_q, par_hold_d;
  logic req_q, req_d;
  logic busy_d;

  always_ff @(posedge lclk) begin
    lrst_s1 <= srst;
    lrst_s2 <= lrst_s1;
    lce_s1 <= ce;
    lce_s2 <= lce_s1;
  end

  function automatic logic needs_param(input logic [7:0] c);
    needs_param = (c == `PMCH_CMD_SYNC_ON) || (c == `PMCH_CMD_SCAN_ORDER);
  endfunction

  function automatic logic no_param(input logic [7:0] c);
    no_param = (c == `PMCH_CMD_SYNC_OFF) || (c == `PMCH_CMD_LOW_COLOR_EXIT) ||
               (c == `PMCH_CMD_LOW_COLOR_ENTRY);
  endfunction

  always_comb begin
    lstate_d = lstate_q;
    cmd_hold_d = cmd_hold_q;
    par_hold_d = par_hold_q;
    req_d = req_q;
    unique case (lstate_q)
      pmch_pkg::PMCH_L_IDLE, pmch_pkg::PMCH_L_PARAM: begin
        if (lnk_valid && lnk_is_cmd) begin
          // A new command code abandons any parameter still awaited.
          if (needs_param(lnk_data)) begin
            cmd_hold_d = lnk_data;
            lstate_d = pmch_pkg::PMCH_L_PARAM;
          end else if (no_param(lnk_data)) begin
            cmd_hold_d = lnk_data;
            par_hold_d = 8'h00;
            req_d = ~req_q;
            lstate_d = pmch_pkg::PMCH_L_WAIT;
          end else begin
            lstate_d = pmch_pkg::PMCH_L_IDLE;
          end
        end else if (lnk_valid && (lstate_q == pmch_pkg::PMCH_L_PARAM)) begin
          par_hold_d = lnk_data;
          req_d = ~req_q;
          lstate_d = pmch_pkg::PMCH_L_WAIT;
        end
      end
      pmch_pkg::PMCH_L_WAIT: begin
        // The held word must stay stable until the core domain has taken it.
        if (ack_s2 == req_q) begin
          lstate_d = pmch_pkg::PMCH_L_IDLE;
        end
      end
      default: begin
        lstate_d = pmch_pkg::PMCH_L_IDLE;
      end
    endcase
    busy_d = (lstate_d == pmch_pkg::PMCH_L_WAIT);
  end

  always_ff @(posedge lclk) begin
    ack_s1 <= ack_q;
    ack_s2 <= ack_s1;
    if (lrst_s2) begin
      lstate_q <= pmch_pkg::PMCH_L_IDLE;
      cmd_hold_q <= 8'h00;
      par_hold_q <= 8'h00;
      req_q <= 1'b0;
      lnk_busy_q <= 1'b0;
    end else if (lce_s2) begin
      lstate_q <= lstate_d;
      cmd_hold_q <= cmd_hold_d;
      par_hold_q <= par_hold_d;
      req_q <= req_d;
      lnk_busy_q <= busy_d;
    end
  end

  // Core domain.
  localparam logic [7:0] SYNC_CTRL_RST = `PMCH_SYNC_CTRL_RESET;
  logic req_s1, req_s2;
  logic sleep_s1, sleep_s2;
  logic apply;
  pmch_pkg::pmch_byte_t apply_cmd, apply_par;
  logic sync_on_q, sync_on_d, hbl_incl_q, hbl_incl_d;
  logic color_swap_d, source_dir_d, gate_dir_d, low_color_d;
  logic frame_sync_d, idle_render_d, pix_out_valid_d;
  logic [23:0] pix_out_d;
  logic [7:0] ch_r, ch_g, ch_b;

  always_ff @(posedge mclk) begin
    req_s1 <= req_q;
    req_s2 <= req_s1;
    sleep_s1 <= sleep_in;
    sleep_s2 <= sleep_s1;
  end

  // The command word is quiet by the time the toggle arrives, so it is read directly.
  assign apply = (req_s2 != ack_q);
  assign apply_cmd = cmd_hold_q;
  assign apply_par = par_hold_q;

  always_comb begin
    ack_d = req_s2;
    sync_on_d = sync_on_q;
    hbl_incl_d = hbl_incl_q;
    color_swap_d = color_order_swap_q;
    source_dir_d = source_direction_q;
    gate_dir_d = gate_direction_q;
    low_color_d = low_color_q;
    if (swrst) begin
      sync_on_d = 1'b0;
      hbl_incl_d = SYNC_CTRL_RST[`PMCH_SYNC_HBLANK_BIT];
      color_swap_d = 1'b0;
      source_dir_d = 1'b0;
      gate_dir_d = 1'b0;
      low_color_d = 1'b0;
    end else if (apply) begin
      unique case (apply_cmd)
        `PMCH_CMD_SYNC_ON: begin
          if (!sync_on_q) begin
            sync_on_d = 1'b1;
            hbl_incl_d = apply_par[`PMCH_SYNC_HBLANK_BIT];
          end
        end
        `PMCH_CMD_SYNC_OFF: sync_on_d = 1'b0;
        `PMCH_CMD_SCAN_ORDER: begin
          color_swap_d = apply_par[`PMCH_SCAN_COLOR_SWAP_BIT];
          source_dir_d = apply_par[`PMCH_SCAN_SOURCE_DIR_BIT];
          gate_dir_d = apply_par[`PMCH_SCAN_GATE_DIR_BIT];
        end
        `PMCH_CMD_LOW_COLOR_EXIT: low_color_d = 1'b0;
        `PMCH_CMD_LOW_COLOR_ENTRY: low_color_d = 1'b1;
        default: begin
        end
      endcase
    end
    if (sleep_s2 || !sync_on_q) begin
      frame_sync_d = 1'b0;
    end else begin
      frame_sync_d = vblank || (hbl_incl_q && hblank);
    end
    idle_render_d = low_color_q && !sleep_s2;
    ch_r = color_order_swap_q ? pix_in[7:0] : pix_in[23:16];
    ch_g = pix_in[15:8];
    ch_b = color_order_swap_q ? pix_in[23:16] : pix_in[7:0];
    if (idle_render_d) begin
      // Reduced depth keeps one bit per channel and expands it to full scale.
      ch_r = {8{ch_r[7]}};
      ch_g = {8{ch_g[7]}};
      ch_b = {8{ch_b[7]}};
    end
    pix_out_d = {ch_r, ch_g, ch_b};
    pix_out_valid_d = pix_valid;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      ack_q <= 1'b0;
      sync_on_q <= 1'b0;
      hbl_incl_q <= 1'b0;
      color_order_swap_q <= 1'b0;
      source_direction_q <= 1'b0;
      gate_direction_q <= 1'b0;
      low_color_q <= 1'b0;
      frame_sync_out_q <= 1'b0;
      idle_render_q <= 1'b0;
      pix_out_q <= 24'h000000;
      pix_out_valid_q <= 1'b0;
    end else if (ce) begin
      ack_q <= ack_d;
      sync_on_q <= sync_on_d;
      hbl_incl_q <= hbl_incl_d;
      color_order_swap_q <= color_swap_d;
      source_direction_q <= source_dir_d;
      gate_direction_q <= gate_dir_d;
      low_color_q <= low_color_d;
      frame_sync_out_q <= frame_sync_d;
      idle_render_q <= idle_render_d;
      pix_out_q <= pix_out_d;
      pix_out_valid_q <= pix_out_valid_d;
    end
  end

  sequence seq_take(logic [7:0] code);
    ce && !swrst && apply && (apply_cmd == code);
  endsequence

  sequence seq_awake_on;
    ce && sync_on_q && !sleep_s2;
  endsequence

  AST_SLEEP_LOW: assert property (@(posedge mclk) disable iff (srst)
    (ce && sleep_s2) |=> !frame_sync_out_q)
    else $error("Sync output high during sleep.");

  AST_SYNC_ON: assert property (@(posedge mclk) disable iff (srst)
    seq_take(`PMCH_CMD_SYNC_ON) |=> sync_on_q)
    else $error("Sync-on command did not enable output.");

  AST_VBLANK_ONLY: assert property (@(posedge mclk) disable iff (srst)
    (seq_awake_on and (ce && !hbl_incl_q && hblank && !vblank)) |=> !frame_sync_out_q)
    else $error("Sync pulsed on horizontal blanking in vertical-only mode.");

  AST_HBLANK_INCL: assert property (@(posedge mclk) disable iff (srst)
    (seq_awake_on and (ce && hbl_incl_q && hblank)) |=> frame_sync_out_q)
    else $error("Sync missed horizontal blanking in combined mode.");

  AST_SYNC_REPEAT: assert property (@(posedge mclk) disable iff (srst)
    (seq_take(`PMCH_CMD_SYNC_ON) and (ce && sync_on_q)) |=> hbl_incl_q == $past(hbl_incl_q))
    else $error("Repeated sync-on changed the mode.");

  AST_SCAN_STORE: assert property (@(posedge mclk) disable iff (srst)
    seq_take(`PMCH_CMD_SCAN_ORDER) |=>
      (color_order_swap_q == $past(apply_par[`PMCH_SCAN_COLOR_SWAP_BIT])) &&
      (source_direction_q == $past(apply_par[`PMCH_SCAN_SOURCE_DIR_BIT])) &&
      (gate_direction_q == $past(apply_par[`PMCH_SCAN_GATE_DIR_BIT])))
    else $error("Scan order bits not stored from parameter.");

  AST_SCAN_KEEP: assert property (@(posedge mclk) disable iff (srst)
    seq_take(`PMCH_CMD_SCAN_ORDER) |=>
      $stable(low_color_q) && $stable(sync_on_q) && $stable(hbl_incl_q))
    else $error("Scan order command disturbed other state.");

  AST_LOW_EXIT: assert property (@(posedge mclk) disable iff (srst)
    seq_take(`PMCH_CMD_LOW_COLOR_EXIT) |=> !low_color_q ##1 !idle_render_q)
    else $error("Reduced color exit did not restore full color.");

  AST_LOW_ENTRY: assert property (@(posedge mclk) disable iff (srst)
    seq_take(`PMCH_CMD_LOW_COLOR_ENTRY) |=> low_color_q)
    else $error("Reduced color entry not taken.");

  AST_RENDER: assert property (@(posedge mclk) disable iff (srst)
    (ce && pix_valid && low_color_q && !sleep_s2) |=>
      ((pix_out_q[23:16] == 8'h00) || (pix_out_q[23:16] == 8'hFF)) &&
      ((pix_out_q[7:0] == 8'h00) || (pix_out_q[7:0] == 8'hFF)) && idle_render_q)
    else $error("Reduced color pixels not rendered at reduced depth.");

  AST_SYNC_OFF: assert property (@(posedge mclk) disable iff (srst)
    seq_take(`PMCH_CMD_SYNC_OFF) |=> !sync_on_q ##1 !frame_sync_out_q || !ce)
    else $error("Sync-off did not silence the output.");

  AST_SW_RESET: assert property (@(posedge mclk) disable iff (srst)
    (ce && swrst) |=> !sync_on_q && !low_color_q && !color_order_swap_q &&
      !source_direction_q && !gate_direction_q)
    else $error("Software reset left state set.");

  AST_SLEEP_ACCEPT: assert property (@(posedge mclk) disable iff (srst)
    (seq_take(`PMCH_CMD_LOW_COLOR_ENTRY) and (ce && sleep_s2)) |=> low_color_q ##1 !idle_render_q)
    else $error("Command refused during sleep.");

endmodule

//--- tb/pmch_host_model.sv
`timescale 1ns/1ps
module pmch_host_model (
  input wire logic lclk,
  input wire logic lnk_busy_q,
  output logic lnk_valid,
  output logic lnk_is_cmd,
  output logic [7:0] lnk_data
);
  initial begin
    lnk_valid = 1'b0;
    lnk_is_cmd = 1'b0;
    lnk_data = 8'h00;
  end

  // A released data line shows the inverse, so a late sample cannot match.
  task automatic put(input logic is_cmd, input logic [7:0] b);
    @(posedge lclk);
    #2;
    lnk_valid = 1'b1;
    lnk_is_cmd = is_cmd;
    lnk_data = b;
    @(posedge lclk);
    #2;
    lnk_valid = 1'b0;
    lnk_data = ~b;
  endtask

  task automatic send(input logic [7:0] c, input logic hp, input logic [7:0] p,
                      output logic ok);
    int n;
    int m;
    n = 0;
    m = 0;
    while (lnk_busy_q !== 1'b0 && n < 60) begin
      @(posedge lclk);
      n++;
    end
    ok = (n < 60);
    put(1'b1, c);
    if (hp) begin
      put(1'b0, p);
    end
    while (lnk_busy_q !== 1'b1 && m < 10) begin
      @(posedge lclk);
      m++;
    end
    n = 0;
    while (lnk_busy_q !== 1'b0 && n < 60) begin
      @(posedge lclk);
      n++;
    end
    ok = ok && (m < 10) && (n < 60);
  endtask
endmodule

//--- tb/panel_mode_command_handler_tb.sv
`timescale 1ns/1ps
module panel_mode_command_handler_tb;
  logic mclk, srst, ce, swrst, sleep_in, vblank, hblank, pix_valid, lclk;
  logic [23:0] pix_in;
  logic lnk_valid, lnk_is_cmd, lnk_busy_q, frame_sync_out_q, color_order_swap_q;
  logic [7:0] lnk_data;
  logic source_direction_q, gate_direction_q, low_color_q, idle_render_q, pix_out_valid_q;
  logic [23:0] pix_out_q;
  logic [7:0] scan_vals [4] = '{8'h08, 8'h02, 8'h01, 8'h0B};
  int fails;
  int checks_done;

  pmch_top dut (.mclk(mclk), .srst(srst), .ce(ce), .swrst(swrst), .sleep_in(sleep_in),
    .vblank(vblank), .hblank(hblank), .pix_valid(pix_valid), .pix_in(pix_in), .lclk(lclk),
    .lnk_valid(lnk_valid), .lnk_is_cmd(lnk_is_cmd), .lnk_data(lnk_data),
    .lnk_busy_q(lnk_busy_q), .frame_sync_out_q(frame_sync_out_q),
    .color_order_swap_q(color_order_swap_q), .source_direction_q(source_direction_q),
    .gate_direction_q(gate_direction_q), .low_color_q(low_color_q),
    .idle_render_q(idle_render_q), .pix_out_valid_q(pix_out_valid_q), .pix_out_q(pix_out_q));

  pmch_host_model host (.lclk(lclk), .lnk_busy_q(lnk_busy_q), .lnk_valid(lnk_valid),
    .lnk_is_cmd(lnk_is_cmd), .lnk_data(lnk_data));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  initial begin
    lclk = 1'b0;
    #7;
    forever #15 lclk = ~lclk;
  end

  task automatic finish_test();
    $display("fails=%0d checks_done=%0d", fails, checks_done);
    if (fails == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic chk_px(input logic [23:0] exp, input logic [23:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected pix_out_q expected %h seen %h", exp, got);
    end
  endtask

  task automatic cmd(input logic [7:0] c, input logic hp, input logic [7:0] p);
    logic ok;
    host.send(c, hp, p, ok);
    chk("link_ack", 1'b1, ok);
    if (ok !== 1'b1) begin
      finish_test();
    end
    repeat (3) @(posedge mclk);
    #2;
  endtask

  task automatic blank(input logic v, input logic h, input logic exp);
    vblank = v;
    hblank = h;
    repeat (2) @(posedge mclk);
    #2;
    chk("frame_sync_out_q", exp, frame_sync_out_q);
  endtask

  initial begin
    srst = 1'b1;
    ce = 1'b1;
    swrst = 1'b0;
    sleep_in = 1'b0;
    vblank = 1'b0;
    hblank = 1'b0;
    pix_valid = 1'b0;
    pix_in = 24'h000000;
    fails = 0;
    checks_done = 0;
    repeat (6) @(posedge mclk);
    #2;
    srst = 1'b0;
    repeat (6) @(posedge mclk);
    #2;
    chk("low_color_q", 1'b0, low_color_q);
    chk("color_order_swap_q", 1'b0, color_order_swap_q);
    blank(1'b1, 1'b1, 1'b0);
    for (int i = 0; i < 4; i++) begin
      cmd(8'h36, 1'b1, scan_vals[i]);
      chk("color_order_swap_q", scan_vals[i][3], color_order_swap_q);
      chk("source_direction_q", scan_vals[i][1], source_direction_q);
      chk("gate_direction_q", scan_vals[i][0], gate_direction_q);
      chk("low_color_q", 1'b0, low_color_q);
    end
    cmd(8'h39, 1'b0, 8'h00);
    chk("low_color_q", 1'b1, low_color_q);
    chk("idle_render_q", 1'b1, idle_render_q);
    pix_valid = 1'b1;
    pix_in = 24'h807F40;
    @(posedge mclk);
    #2;
    pix_valid = 1'b0;
    chk("pix_out_valid_q", 1'b1, pix_out_valid_q);
    chk_px(24'h0000FF, pix_out_q);
    cmd(8'h39, 1'b0, 8'h00);
    chk("low_color_q", 1'b1, low_color_q);
    cmd(8'h38, 1'b0, 8'h00);
    chk("low_color_q", 1'b0, low_color_q);
    cmd(8'h38, 1'b0, 8'h00);
    chk("low_color_q", 1'b0, low_color_q);
    // Full depth again, with red and blue still swapped by the last scan byte.
    pix_valid = 1'b1;
    pix_in = 24'h123456;
    @(posedge mclk);
    #2;
    pix_valid = 1'b0;
    chk_px(24'h563412, pix_out_q);
    cmd(8'h35, 1'b1, 8'h00);
    blank(1'b1, 1'b0, 1'b1);
    blank(1'b0, 1'b1, 1'b0);
    cmd(8'h35, 1'b1, 8'h01);
    blank(1'b0, 1'b1, 1'b0);
    cmd(8'h34, 1'b0, 8'h00);
    blank(1'b1, 1'b0, 1'b0);
    cmd(8'h35, 1'b1, 8'h01);
    blank(1'b0, 1'b1, 1'b1);
    sleep_in = 1'b1;
    repeat (4) @(posedge mclk);
    #2;
    blank(1'b1, 1'b1, 1'b0);
    cmd(8'h39, 1'b0, 8'h00);
    chk("low_color_q", 1'b1, low_color_q);
    chk("idle_render_q", 1'b0, idle_render_q);
    sleep_in = 1'b0;
    swrst = 1'b1;
    @(posedge mclk);
    #2;
    swrst = 1'b0;
    repeat (4) @(posedge mclk);
    #2;
    blank(1'b1, 1'b1, 1'b0);
    chk("low_color_q", 1'b0, low_color_q);
    chk("color_order_swap_q", 1'b0, color_order_swap_q);
    chk("gate_direction_q", 1'b0, gate_direction_q);
    finish_test();
  end
endmodule
